// ---- tb/cpu_interrupt_exception_dispatch_tb.sv ----
// Self-checking bench for the interrupt and exception dispatch unit
`timescale 1ns/1ns
`default_nettype none
module cpu_interrupt_exception_dispatch_tb;
  import ied_pkg::*;
  typedef struct packed {logic [7:0] vt; logic [15:0] ip; logic ck; logic ack;} ied_exp_t;
  logic i_clk = 1'b0, i_rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, nmi = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'b00;
  logic hready, hresp, ack, disp;
  logic [7:0] pvec, pv, nack;
  ied_dispatch_t d;
  ied_exp_t q[$];
  int fails = 0, n_compared = 0, seed = 4;
  logic [15:0] nip;
  logic [7:0] sv;
  always #5 i_clk = ~i_clk;
  ied_dispatch i_ied_dispatch (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .i_nmi(nmi), .o_ack_cycle(ack), .o_dispatch(disp), .o_disp(d));
  ied_ack_partner i_ied_ack_partner (.i_clk(i_clk), .i_ack(ack), .i_vec(pv), .o_vec(pvec),
    .o_n_ack(nack));
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Each dispatch pulse consumes the oldest expected record
  always @(posedge i_clk)
  begin
    if (disp === 1'b1)
    begin
      if (q.size() == 0)
        chk(32'h1, 32'h0);
      else
      begin
        chk(d.vtype, q[0].vt);
        chk(d.entry_addr, {q[0].vt, 2'b00});
        chk(d.via_ack, q[0].ack);
        if (q[0].ack)
          chk(d.vtype, {24'h0, pvec});
        if (q[0].ck)
          chk(d.ret_ip, q[0].ip);
        void'(q.pop_front());
      end
    end
  end
  // ----------------------------------------------------------------
  // Bus master: one single word transfer per call
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge i_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge i_clk); while (hready !== 1'b1);
    r = hrdata;
    chk(hresp, 1'b0);
  endtask
  // Boundary or exception write; expectation noted before the request
  task automatic exc(input logic [3:0] c, input logic [7:0] v, input logic [1:0] f,
                     input logic e, input logic [7:0] vt, input logic [15:0] ip,
                     input logic ck, input logic a);
    bus(1'b1, IED_RET_OFS, {nip - 16'h0002, nip});
    if (e)
      q.push_back('{vt, ip, ck, a});
    bus(1'b1, IED_EXC_OFS, {14'h0, f, v, 4'h0, c});
    repeat (3) @(posedge i_clk);
    chk(q.size(), 0);
  endtask
  initial
  begin
    #200000;
    fails++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] vts[7];
    logic [12:0] reqs[4];
    logic [7:0] rvt[4];
    pv = 8'h5a;
    vts = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h00, 8'h03};
    reqs = '{13'h007, 13'h1f8, 13'h030, 13'h100};
    rvt = '{8'h08, 8'h0a, 8'h0b, 8'h0f};
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    bus(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0);
    bus(1'b0, IED_CTRL_OFS, 32'h0);
    chk(r[3:0], IED_CTRL_RST);
    // Every exception code with its vector and return address
    bus(1'b1, IED_CTRL_OFS, 32'h0000000c);
    for (int i = 1; i <= 7; i++)
    begin
      nip = $random(seed);
      sv = $random(seed);
      exc(i[3:0], sv, 2'b00, 1'b1, (i == 6) ? sv : vts[i - 1],
          (i == 5) ? nip - 16'h0002 : nip, 1'b1, 1'b0);
    end
    bus(1'b0, IED_ENTRY_OFS, 32'h0);
    chk(r[25:8], {10'h00c, 8'h03});
    exc(IED_EX_ESC, 8'h00, 2'b01, 1'b1, 8'h07, nip - 16'h0003, 1'b1, 1'b0);
    exc(IED_EX_RANGE, 8'h00, 2'b00, 1'b1, 8'h05, nip, 1'b1, 1'b0);
    // Overflow trap and escape without their enables do nothing
    bus(1'b1, IED_CTRL_OFS, 32'h0);
    exc(IED_EX_OVFTRAP, 8'h00, 2'b00, 1'b0, 8'h00, 16'h0, 1'b0, 1'b0);
    exc(IED_EX_ESC, 8'h00, 2'b00, 1'b0, 8'h00, 16'h0, 1'b0, 1'b0);
    // Maskable requests gated by the enable flag
    bus(1'b1, IED_HWREQ_OFS, 32'h0000003e);
    exc(IED_EX_BOUNDARY, 8'h00, 2'b00, 1'b0, 8'h00, 16'h0, 1'b0, 1'b0);
    bus(1'b1, IED_CTRL_OFS, 32'h00000001);
    exc(IED_EX_BOUNDARY, 8'h00, 2'b00, 1'b1, 8'h12, nip, 1'b0, 1'b0);
    bus(1'b0, IED_RET_OFS, 32'h0);
    chk(r[16 + IED_CTRL_IE_BIT], 1'b1);
    exc(IED_EX_BOUNDARY, 8'h00, 2'b00, 1'b0, 8'h00, 16'h0, 1'b0, 1'b0);
    q.push_back('{8'h12, 16'h0, 1'b0, 1'b0});
    bus(1'b1, IED_INTERRUPT_RETURN_OFS, 32'h00000001);
    repeat (3) @(posedge i_clk);
    chk(q.size(), 0);
    // Default priority order across the maskable sources
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, IED_HWREQ_OFS, {19'h0, reqs[i]});
      bus(1'b1, IED_CTRL_OFS, 32'h00000001);
      exc(IED_EX_BOUNDARY, 8'h00, 2'b00, 1'b1, rvt[i], 16'h0, 1'b0, 1'b0);
    end
    // Cascaded line fetches its vector by acknowledge
    bus(1'b1, IED_ACKVEC_OFS, {24'h0, pv});
    bus(1'b1, IED_HWREQ_OFS, 32'h00000220);
    bus(1'b1, IED_CTRL_OFS, 32'h00000001);
    exc(IED_EX_BOUNDARY, 8'h00, 2'b00, 1'b1, pv, 16'h0, 1'b0, 1'b1);
    chk(nack, 8'h01);
    // Non-maskable request with the enable flag clear
    bus(1'b1, IED_HWREQ_OFS, 32'h0);
    bus(1'b1, IED_CTRL_OFS, 32'h0);
    nmi <= 1'b1;
    repeat (4) @(posedge i_clk);
    nmi <= 1'b0;
    bus(1'b0, IED_STATUS_OFS, 32'h0);
    chk(r[0], 1'b1);
    exc(IED_EX_BOUNDARY, 8'h00, 2'b00, 1'b1, IED_VT_NMI, 16'h0, 1'b0, 1'b0);
    chk(nack, 8'h01);
    // Single step: blocked after a step-blocking instruction, then once, then cleared
    bus(1'b1, IED_CTRL_OFS, 32'h00000002);
    exc(IED_EX_BOUNDARY, 8'h00, 2'b10, 1'b0, 8'h00, 16'h0, 1'b0, 1'b0);
    exc(IED_EX_BOUNDARY, 8'h00, 2'b00, 1'b1, IED_VT_STEP, 16'h0, 1'b0, 1'b0);
    exc(IED_EX_BOUNDARY, 8'h00, 2'b00, 1'b0, 8'h00, 16'h0, 1'b0, 1'b0);
    give_verdict();
  end
endmodule // cpu_interrupt_exception_dispatch_tb
`default_nettype wire

// ---- tb/ied_ack_partner.sv ----
// Model of the external controller that answers acknowledge sequences
`timescale 1ns/1ns
`default_nettype none
module ied_ack_partner (
  // Clock and acknowledge from the block
  input wire logic i_clk,
  input wire logic i_ack,
  // Vector held for the next acknowledge, and acknowledges seen
  input wire logic [7:0] i_vec,
  output logic [7:0] o_vec,
  output logic [7:0] o_n_ack
);
  // The vector is presented only while an acknowledge runs
  always_comb o_vec = i_ack ? i_vec : ~i_vec;
  // Count acknowledges so the bench can tell a vector was fetched
  initial o_n_ack = 8'h00;
  always @(posedge i_clk)
  begin
    if (i_ack === 1'b1)
      o_n_ack <= o_n_ack + 8'h01;
  end
endmodule // ied_ack_partner
`default_nettype wire

// ---- verilog/ied_dispatch.sv ----
// Interrupt and exception dispatch unit with an AHB-Lite register port
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Save status word and return address on entry
// - Escape trap returns to opcode or prefix
// - Other exceptions return past faulting instruction
// - Table of 256 pointers, types 0-31 reserved
// - Entry address is type times four
// - External vector taken during acknowledge sequence
// - On-chip sources supply their own vectors
// - Exceptions internal; software traps reach all 256
// - Hardware sampled only at instruction boundaries
// - Quotient overflow raises type 0
// - Trace type 1, not after prefix/segment/wait
// - Breakpoint is type 3, offset 12
// - Overflow trap only when overflow flag set
// - Range check failure raises type 5
// - Undefined opcode raises type 6
// - Escape opcodes trap type 7 when enabled
// - Timers share one slot, 0 over 1 over 2
// - Default priority NMI, timers, reserved, DMA, external
// - Maskable sources need the enable flag
// - Entry clears enable after saving status
// - Return restores enable and trace; pending maskable serviced at once
// - Enabled routine may be preempted
// - Non-maskable ignores flag, clears it
// - Non-maskable uses type 2, no acknowledge
// - Step trap clears trace; return sets it
module ied_dispatch
  import ied_pkg::*;
#(
  parameter int EXT_LINES = 4
)(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Non-maskable request pin
  input wire logic i_nmi,
  // Acknowledge sequence toward the external controller
  output logic o_ack_cycle,
  // Dispatch record
  output logic o_dispatch,
  output ied_dispatch_t o_disp
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic nmi_s1_r;
  logic nmi_s2_r;
  logic nmi_d_r;

  // Two flops before any logic reads the pin
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      nmi_s1_r <= 1'b0;
      nmi_s2_r <= 1'b0;
      nmi_d_r <= 1'b0;
    end
    else if (i_ce)
    begin
      nmi_s1_r <= i_nmi;
      nmi_s2_r <= nmi_s1_r;
      nmi_d_r <= nmi_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic ap_wr_r;
  logic ap_rd_r;
  logic [7:0] ap_addr_r;
  logic wr_go;

  // Zero wait states; response is always OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // Capture address phase
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ap_wr_r <= 1'b0;
      ap_rd_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end
    else if (i_ce && i_hready)
    begin
      ap_wr_r <= i_hsel && i_htrans[1] && i_hwrite;
      ap_rd_r <= i_hsel && i_htrans[1] && !i_hwrite;
      ap_addr_r <= i_haddr[7:0];
    end
  end

  assign wr_go = ap_wr_r && i_ce;

  // ----------------------------------------------------------------
  // Software-visible state
  // ----------------------------------------------------------------
  logic ie_r;
  logic tf_r;
  logic of_r;
  logic esct_r;
  logic [15:0] hwreq_r;
  logic [7:0] ackvec_r;
  logic [15:0] next_ip_r;
  logic [15:0] cur_ip_r;
  logic prefix;
  logic [7:0] swvec;
  logic step_blk;
  logic [3:0] exc_code;
  logic boundary;
  logic interrupt_return_go;
  logic [15:0] interrupt_return_psw;

  // Exception register: [3:0] code, [7:4] unused, [15:8] vector
  // [16] seg-override prefix present, [17] step-blocking instruction
  assign exc_code = wr_go && (ap_addr_r == IED_EXC_OFS) ? i_hwdata[3:0] : IED_EX_NONE;
  assign boundary = exc_code != IED_EX_NONE;
  assign interrupt_return_go = wr_go && (ap_addr_r == IED_INTERRUPT_RETURN_OFS);
  assign interrupt_return_psw = i_hwdata[15:0];

  // Return-address register: [15:0] next IP, [31:16] current IP
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      next_ip_r <= 16'h0000;
      cur_ip_r <= 16'h0000;
      hwreq_r <= 16'h0000;
      ackvec_r <= 8'h00;
      esct_r <= 1'b0;
      of_r <= 1'b0;
    end
    else if (wr_go)
    begin
      if (ap_addr_r == IED_RET_OFS)
      begin
        next_ip_r <= i_hwdata[15:0];
        cur_ip_r <= i_hwdata[31:16];
      end
      if (ap_addr_r == IED_HWREQ_OFS)
        hwreq_r <= i_hwdata[15:0];
      if (ap_addr_r == IED_ACKVEC_OFS)
        ackvec_r <= i_hwdata[7:0];
      if (ap_addr_r == IED_CTRL_OFS)
      begin
        esct_r <= i_hwdata[IED_CTRL_ESCT_BIT];
        of_r <= i_hwdata[IED_CTRL_OF_BIT];
      end
    end
  end

  // Per-instruction attributes ride on the same data phase as the code;
  // a latched copy would lag the boundary by one write
  assign prefix = i_hwdata[16];
  assign swvec = i_hwdata[15:8];
  assign step_blk = i_hwdata[17];

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  logic exc_take;
  logic [7:0] exc_vt;
  logic hw_take;
  logic [7:0] hw_vt;
  logic hw_ack;
  logic step_take;
  logic nmi_edge;
  logic nmi_pend_r;

  // Non-maskable is edge-triggered and held until serviced
  assign nmi_edge = nmi_s2_r && !nmi_d_r;

  // Map the instruction outcome to an internal vector
  always_comb
  begin
    exc_take = 1'b0;
    exc_vt = IED_VT_DIV;
    unique case (exc_code)
      IED_EX_DIVOVF:
      begin
        exc_take = 1'b1;
        exc_vt = IED_VT_DIV;
      end
      IED_EX_OVFTRAP:
      begin
        exc_take = of_r;
        exc_vt = IED_VT_OVF;
      end
      IED_EX_RANGE:
      begin
        exc_take = 1'b1;
        exc_vt = IED_VT_RANGE;
      end
      IED_EX_UNDEF:
      begin
        exc_take = 1'b1;
        exc_vt = IED_VT_UNDEF;
      end
      IED_EX_ESC:
      begin
        exc_take = esct_r;
        exc_vt = IED_VT_ESC;
      end
      IED_EX_SWINT:
      begin
        exc_take = 1'b1;
        exc_vt = swvec;
      end
      IED_EX_BRK:
      begin
        exc_take = 1'b1;
        exc_vt = IED_VT_BRK;
      end
      default:
      begin
        exc_take = 1'b0;
        exc_vt = IED_VT_DIV;
      end
    endcase
  end

  // Trace trap after most instructions, blocked after some kinds
  assign step_take = boundary && tf_r && !step_blk;

  // Fixed default priority; hwreq bits: 0-2 timers, 3-4 DMA, 5-8 lines, 9-12 cascade flags
  always_comb
  begin
    hw_take = 1'b0;
    hw_vt = IED_VT_TMR0;
    hw_ack = 1'b0;
    // On a return the restored enable decides, not the cleared one
    if (interrupt_return_go ? interrupt_return_psw[IED_CTRL_IE_BIT] : ie_r)
    begin
      if (hwreq_r[0])
      begin
        hw_take = 1'b1;
        hw_vt = IED_VT_TMR0;
      end
      else if (hwreq_r[1])
      begin
        hw_take = 1'b1;
        hw_vt = IED_VT_TMR1;
      end
      else if (hwreq_r[2])
      begin
        hw_take = 1'b1;
        hw_vt = IED_VT_TMR2;
      end
      else if (hwreq_r[3])
      begin
        hw_take = 1'b1;
        hw_vt = IED_VT_DMA0;
      end
      else if (hwreq_r[4])
      begin
        hw_take = 1'b1;
        hw_vt = IED_VT_DMA1;
      end
      else
      begin
        for (int k = EXT_LINES - 1; k >= 0; k--)
        begin
          if (hwreq_r[5 + k])
          begin
            hw_take = 1'b1;
            hw_vt = IED_VT_EXT0 + 8'(k);
            hw_ack = hwreq_r[9 + k]; // Cascaded line needs the controller
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Dispatch
  // ----------------------------------------------------------------
  logic fire;
  logic [7:0] vt;
  logic via_ack;
  logic [15:0] ret_ip;
  logic [15:0] psw_now;
  logic nmi_take;

  function automatic logic [9:0] entry_of(input logic [7:0] t);
    entry_of = {t, 2'b00};
  endfunction

  assign psw_now = {12'h000, esct_r, of_r, tf_r, ie_r};

  // Exceptions and software traps first, then NMI, then trace, then maskable
  always_comb
  begin
    fire = 1'b0;
    vt = IED_VT_DIV;
    via_ack = 1'b0;
    nmi_take = 1'b0;
    ret_ip = next_ip_r;
    if (exc_take)
    begin
      fire = 1'b1;
      vt = exc_vt;
      if (exc_code == IED_EX_ESC)
        ret_ip = prefix ? cur_ip_r - 16'h0001 : cur_ip_r;
    end
    else if (boundary && (nmi_pend_r || nmi_edge))
    begin
      fire = 1'b1;
      nmi_take = 1'b1;
      vt = IED_VT_NMI;
    end
    else if (step_take)
    begin
      fire = 1'b1;
      vt = IED_VT_STEP;
    end
    else if ((boundary || interrupt_return_go) && hw_take)
    begin
      fire = 1'b1;
      vt = via_ack_vec(hw_ack, hw_vt);
      via_ack = hw_ack;
    end
  end

  function automatic logic [7:0] via_ack_vec(input logic a, input logic [7:0] v);
    via_ack_vec = a ? ackvec_r : v;
  endfunction

  // Latched non-maskable request, set wins over service
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      nmi_pend_r <= 1'b0;
    else if (i_ce)
    begin
      // An edge served in its own cycle must not be remembered twice
      if (nmi_edge && (nmi_pend_r || !nmi_take))
        nmi_pend_r <= 1'b1;
      else if (nmi_take)
        nmi_pend_r <= 1'b0;
    end
  end

  // Enable and trace flags: entry clears after the status is saved
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ie_r <= IED_CTRL_RST[IED_CTRL_IE_BIT];
      tf_r <= IED_CTRL_RST[IED_CTRL_TF_BIT];
    end
    else if (i_ce)
    begin
      if (fire)
      begin
        ie_r <= 1'b0;
        tf_r <= 1'b0;
      end
      else if (interrupt_return_go)
      begin
        ie_r <= interrupt_return_psw[0];
        tf_r <= interrupt_return_psw[1];
      end
      else if (wr_go && ap_addr_r == IED_CTRL_OFS)
      begin
        ie_r <= i_hwdata[IED_CTRL_IE_BIT];
        tf_r <= i_hwdata[IED_CTRL_TF_BIT];
      end
    end
  end

  // Dispatch record: pushed status and return, then table fetch
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_dispatch <= 1'b0;
      o_ack_cycle <= 1'b0;
      o_disp <= '0;
    end
    else if (i_ce)
    begin
      o_dispatch <= fire;
      o_ack_cycle <= fire && via_ack;
      if (fire)
      begin
        o_disp.saved_psw <= interrupt_return_go ? interrupt_return_psw : psw_now;
        o_disp.ret_ip <= ret_ip;
        o_disp.vtype <= vt;
        o_disp.entry_addr <= entry_of(vt);
        o_disp.via_ack <= via_ack;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_hrdata <= 32'h0000_0000;
    else if (i_ce && i_hready && i_hsel && i_htrans[1] && !i_hwrite)
    begin
      unique case (i_haddr[7:0])
        IED_CTRL_OFS: o_hrdata <= {28'h0, psw_now[3:0]};
        IED_HWREQ_OFS: o_hrdata <= {16'h0, hwreq_r};
        IED_ACKVEC_OFS: o_hrdata <= {24'h0, ackvec_r};
        IED_STATUS_OFS: o_hrdata <= {31'h0, nmi_pend_r};
        IED_ENTRY_OFS: o_hrdata <= {6'h0, o_disp.entry_addr, o_disp.vtype, 8'h0};
        IED_RET_OFS: o_hrdata <= {o_disp.saved_psw, o_disp.ret_ip};
        default: o_hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  entry_times4_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_dispatch |-> o_disp.entry_addr == {o_disp.vtype, 2'b00})
    else $error("entry address not type times four");
  mask_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && fire && !exc_take && !nmi_take && !step_take) |->
    (interrupt_return_go ? interrupt_return_psw[IED_CTRL_IE_BIT] : ie_r))
    else $error("maskable taken with enable clear");
  ie_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && fire) |=> !ie_r)
    else $error("enable flag not cleared on entry");
  brk_vec_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && exc_code == IED_EX_BRK) |=> o_dispatch && o_disp.entry_addr == 10'd12)
    else $error("breakpoint not at offset 12");
  ovf_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && exc_code == IED_EX_OVFTRAP && !of_r && !tf_r && !nmi_pend_r && !nmi_edge
     && !hw_take) |=> !o_dispatch)
    else $error("overflow trap fired with flag clear");
  nmi_noack_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (o_dispatch && o_disp.vtype == IED_VT_NMI) |-> !o_ack_cycle)
    else $error("acknowledge run for non-maskable");
  step_clr_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && fire && vt == IED_VT_STEP) |=> !tf_r)
    else $error("trace flag not cleared");
  save_psw_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && fire && !interrupt_return_go) |=> o_disp.saved_psw[0] == $past(ie_r))
    else $error("saved status lost enable");

endmodule // ied_dispatch

`default_nettype wire

// ---- verilog/ied_pkg.sv ----
// Package for the interrupt and exception dispatch block
package ied_pkg;

  // ----------------------------------------------------------------
  // Register map (word-aligned byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] IED_CTRL_OFS = 8'h00;
  localparam logic [7:0] IED_HWREQ_OFS = 8'h04;
  localparam logic [7:0] IED_EXC_OFS = 8'h08;
  localparam logic [7:0] IED_ACKVEC_OFS = 8'h0c;
  localparam logic [7:0] IED_STATUS_OFS = 8'h10;
  localparam logic [7:0] IED_ENTRY_OFS = 8'h14;
  localparam logic [7:0] IED_RET_OFS = 8'h18;
  localparam logic [7:0] IED_INTERRUPT_RETURN_OFS = 8'h1c;

  // Control register fields
  localparam int IED_CTRL_IE_BIT = 0;
  localparam int IED_CTRL_TF_BIT = 1;
  localparam int IED_CTRL_OF_BIT = 2;
  localparam int IED_CTRL_ESCT_BIT = 3;
  localparam logic [3:0] IED_CTRL_RST = 4'h0;

  // Exception request codes (written to the exception register)
  localparam logic [3:0] IED_EX_NONE = 4'h0;
  localparam logic [3:0] IED_EX_DIVOVF = 4'h1;
  localparam logic [3:0] IED_EX_OVFTRAP = 4'h2;
  localparam logic [3:0] IED_EX_RANGE = 4'h3;
  localparam logic [3:0] IED_EX_UNDEF = 4'h4;
  localparam logic [3:0] IED_EX_ESC = 4'h5;
  localparam logic [3:0] IED_EX_SWINT = 4'h6;
  localparam logic [3:0] IED_EX_BRK = 4'h7;
  localparam logic [3:0] IED_EX_BOUNDARY = 4'h8;

  // Vector types
  localparam logic [7:0] IED_VT_DIV = 8'h00;
  localparam logic [7:0] IED_VT_STEP = 8'h01;
  localparam logic [7:0] IED_VT_NMI = 8'h02;
  localparam logic [7:0] IED_VT_BRK = 8'h03;
  localparam logic [7:0] IED_VT_OVF = 8'h04;
  localparam logic [7:0] IED_VT_RANGE = 8'h05;
  localparam logic [7:0] IED_VT_UNDEF = 8'h06;
  localparam logic [7:0] IED_VT_ESC = 8'h07;
  localparam logic [7:0] IED_VT_TMR0 = 8'h08;
  localparam logic [7:0] IED_VT_DMA0 = 8'h0a;
  localparam logic [7:0] IED_VT_DMA1 = 8'h0b;
  localparam logic [7:0] IED_VT_EXT0 = 8'h0c;
  localparam logic [7:0] IED_VT_TMR1 = 8'h12;
  localparam logic [7:0] IED_VT_TMR2 = 8'h13;
  localparam logic [7:0] IED_VT_RSVD_TOP = 8'h1f;
  localparam int IED_TABLE_ENTRIES = 256;
  localparam int IED_ENTRY_BYTES = 4;

  // Dispatch record handed to the sequencer
  typedef struct packed {
    logic [7:0] vtype;
    logic [9:0] entry_addr;
    logic [15:0] ret_ip;
    logic [15:0] saved_psw;
    logic via_ack;
  } ied_dispatch_t;

endpackage
